// [hw/board_ctl_params.svh]
// Purpose: Named constants of the board control target
// Assumes: 10 MHz system clock
// Notes: Definitions only
`ifndef BOARD_CTL_PARAMS_SVH
`define BOARD_CTL_PARAMS_SVH
// ==========================================
// Bus address and command codes
`define BUS_ADDR 7'h5C
`define CMD_CTRL_WR 8'hA0
`define CMD_CTRL_RD 8'hA1
`define CMD_ST0_CLR 8'hB0
`define CMD_ST0_RD 8'hB1
`define CMD_ST1_CLR 8'hB2
`define CMD_ST1_RD 8'hB3
`define CMD_REV_RD 8'hC1
`define BYTE_BITS 4'h8
// ==========================================
// Reset values
`define CTRL_RST 8'h00
`define REV_DEFAULT 8'h01
// ==========================================
// Timing, each in its own unit
`define CLK_HZ 64'h0098_9680
`define MS_PER_S 64'h3E8
`define US_PER_S 64'hF_4240
`define WD_T0_S 64'h2
`define WD_T1_S 64'hA
`define WD_T2_S 64'h32
`define WD_T3_S 64'hFA
`define BLINK_MS 64'h1F4
`define RST_HOLD_US 64'h64
`endif

// [hw/board_ctl_pkg.sv]
// Purpose: Types of the board control target
// Assumes: Compiled before all design modules
// Notes: Field order follows the register bit order, MSB first
package board_ctl_pkg;
  // ==========================================
  // Register layouts
  typedef struct packed {
    logic green_led_on;
    logic handle_switch_disable;
    logic handle_switch_action_sel;
    logic wd_interval_sel_a;
    logic wd_interval_sel_b;
    logic wd_kick;
    logic red_led_blink;
    logic full_reset_request;
  } ctrl_t;
  typedef struct packed {
    logic fail_rail_a;
    logic fail_rail_b;
    logic fail_rail_c;
    logic fail_rail_sysagent;
    logic fail_rail_lan;
    logic fail_rail_d;
    logic fail_rail_gfx;
    logic fail_rail_core;
  } rail_stat_t;
  typedef struct packed {
    logic rsvd;
    logic wd_reset_cause;
    logic wd_half_elapsed;
    logic [4:0] fail;
  } cause_t;
  // ==========================================
  // Bus engine and state
  typedef enum logic [2:0] {
    BS_IDLE, BS_ADDR, BS_CMD, BS_WDATA, BS_ACK, BS_RDATA, BS_HACK
  } bus_st_t;
  typedef struct packed {
    logic scl;
    logic sda;
    logic sw;
    logic sys_b;
    logic [7:0] f0;
    logic [4:0] f1;
  } pins_t;
  typedef struct packed {
    logic armed;
    logic half;
    logic expire;
  } wd_stat_t;
  typedef struct packed {
    logic [31:0] cnt;
    wd_stat_t st;
  } wd_state_t;
  typedef struct packed {
    pins_t p1;
    pins_t p2;
    logic scl3;
    logic sda3;
    bus_st_t st;
    bus_st_t aft;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [7:0] rsh;
    logic oe;
    ctrl_t ctrl;
    rail_stat_t st0;
    cause_t st1;
    logic [31:0] blink;
    logic blk;
    logic [9:0] hold;
    logic red;
    logic pwr;
    logic sysrst;
  } top_state_t;
endpackage

// [hw/smbus_board_control_status.sv]
// What this block does
// R1 - Answer as one bus target, address 0x5C
// R2 - Host uses single-byte data transfers only
// R3 - Host avoids writing read-only, reading write-only
// R4 - Control written at A0, read A1, resets zero
// R5 - Bit 7 switches green LED on
// R6 - Bit 6 set ignores handle switch presses
// R7 - Bit 5 picks power event or reset
// R8 - Bits 4:3 pick 2/10/50/250 s interval
// R9 - Any bit 2 change restarts watchdog count
// R10 - Watchdog idle after reset, armed by kick
// R11 - Bit 1 makes red LED blink
// R12 - Bit 0 set forces full system reset
// R13 - Rail status bits flag regulator power failures
// R14 - Rail status survives system reset, software clears
// R15 - Writes to B0/B2 clear, read B1/B3
// R16 - Cause status bit 7 reads zero
// R17 - Cause bit 6 flags watchdog reset
// R18 - Cause bit 5 flags half interval used
// R19 - Cause bits sticky except half-time flag
// R20 - Cause bits 4:0 flag rail group failures
// R21 - Revision byte read at C1, not writable
// R22 - Watchdog expiry resets system, sets cause
// R23 - Control read returns last written value
//
// Purpose: Board control and status target on the management bus
// Assumes: SCL and SDA raw from pins, host never clock-stretched
// Notes: Status cleared by rst_b (power-up) and B0/B2 writes; system reset clears only the half-time flag
`include "board_ctl_params.svh"
module smbus_board_control_status
  import board_ctl_pkg::*;
#(
  parameter logic [31:0] WD_CYC0 = 32'(`WD_T0_S * `CLK_HZ),
  parameter logic [31:0] WD_CYC1 = 32'(`WD_T1_S * `CLK_HZ),
  parameter logic [31:0] WD_CYC2 = 32'(`WD_T2_S * `CLK_HZ),
  parameter logic [31:0] WD_CYC3 = 32'(`WD_T3_S * `CLK_HZ),
  parameter logic [31:0] BLINK_CYC = 32'(`BLINK_MS * `CLK_HZ / `MS_PER_S),
  // Arbitrary value
  parameter logic [7:0] REV = `REV_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic handle_sw,
  input wire logic sys_rst_in_b,
  input wire logic [7:0] rail_fail,
  input wire logic [4:0] group_fail,
  output logic green_led,
  output logic red_led,
  output logic power_event,
  output logic sys_reset_out
);
  localparam logic [9:0] HOLD_CYC = 10'(`RST_HOLD_US * `CLK_HZ / `US_PER_S);

  top_state_t s;
  top_state_t n;
  logic [1:0] rst_sync;
  logic rst_n;
  pins_t pins;
  wd_stat_t wd_st;
  logic scl_r;
  logic scl_f;
  logic start;
  logic stop;
  logic byte_done;
  logic wr_go;
  logic clr0;
  logic clr1;
  logic kick;
  logic sys_act;
  logic press;
  ctrl_t wdat;
  logic [7:0] rd_val;

  // ==========================================
  // Reset release
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================
  // Pin sampling and bus events
  assign pins = '{scl: scl_i, sda: sda_i, sw: handle_sw, sys_b: sys_rst_in_b,
                  f0: rail_fail, f1: group_fail};
  // Edges look at the second stage and its delayed copy only
  assign scl_r = s.p2.scl & ~s.scl3;
  assign scl_f = ~s.p2.scl & s.scl3;
  assign start = s.p2.scl & s.scl3 & s.sda3 & ~s.p2.sda;
  assign stop = s.p2.scl & s.scl3 & ~s.sda3 & s.p2.sda;
  assign byte_done = (s.bitc == `BYTE_BITS);
  assign wr_go = (s.st == BS_WDATA) && scl_f && byte_done && !start && !stop;
  assign wdat = ctrl_t'(s.sh);
  assign clr0 = wr_go && (s.cmd == `CMD_ST0_CLR);
  assign clr1 = wr_go && (s.cmd == `CMD_ST1_CLR);
  assign sys_act = ~s.p2.sys_b;
  assign kick = wr_go && (s.cmd == `CMD_CTRL_WR) &&
                (wdat.wd_kick != s.ctrl.wd_kick); // [R9]
  assign press = s.p2.sw & ~s.ctrl.handle_switch_disable; // [R6]

  // ==========================================
  // Read data
  always_comb begin
    case (s.cmd)
      `CMD_CTRL_RD: rd_val = s.ctrl; // [R4] [R23]
      `CMD_ST0_RD: rd_val = s.st0; // [R15]
      `CMD_ST1_RD: rd_val = s.st1; // [R15]
      `CMD_REV_RD: rd_val = REV; // [R21]
      default: rd_val = 8'h00;
    endcase
  end

  // ==========================================
  // Watchdog
  wd_timer #(
    .C0(WD_CYC0),
    .C1(WD_CYC1),
    .C2(WD_CYC2),
    .C3(WD_CYC3)
  ) u_wd (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .disarm(sys_act),
    .kick(kick),
    .sel({s.ctrl.wd_interval_sel_b, s.ctrl.wd_interval_sel_a}), // [R8]
    .stat(wd_st)
  );

  // ==========================================
  // Next state
  always_comb begin
    n = s;
    n.p1 = pins;
    n.p2 = s.p1;
    n.scl3 = s.p2.scl;
    n.sda3 = s.p2.sda;
    // A start anywhere restarts the frame, so repeated start works
    if (start) begin
      n.st = BS_ADDR;
      n.bitc = '0;
      n.oe = 1'b0;
    end else if (stop) begin
      n.st = BS_IDLE;
      n.oe = 1'b0;
    end else begin
      case (s.st)
        BS_IDLE: begin
          n.oe = 1'b0;
        end
        BS_ADDR, BS_CMD, BS_WDATA: begin
          if (scl_r) begin
            n.sh = {s.sh[6:0], s.p2.sda};
            n.bitc = s.bitc + 4'h1;
          end else if (scl_f && byte_done) begin
            n.oe = 1'b1;
            n.st = BS_ACK;
            n.aft = BS_IDLE;
            if (s.st == BS_ADDR) begin
              if (s.sh[7:1] != `BUS_ADDR) begin // [R1]
                n.oe = 1'b0;
                n.st = BS_IDLE;
              end else if (s.sh[0]) begin
                n.aft = BS_RDATA;
                n.rsh = rd_val;
              end else begin
                n.aft = BS_CMD;
              end
            end else if (s.st == BS_CMD) begin
              n.cmd = s.sh;
              n.aft = BS_WDATA;
            end
          end
        end
        BS_ACK: begin
          if (scl_f) begin
            n.bitc = '0;
            n.st = s.aft;
            n.oe = 1'b0;
            if (s.aft == BS_RDATA) begin
              n.oe = ~s.rsh[7];
              n.rsh = {s.rsh[6:0], 1'b0};
              n.bitc = 4'h1;
            end
          end
        end
        BS_RDATA: begin
          if (scl_f) begin
            if (byte_done) begin
              n.oe = 1'b0;
              n.st = BS_HACK;
            end else begin
              n.oe = ~s.rsh[7];
              n.rsh = {s.rsh[6:0], 1'b0};
              n.bitc = s.bitc + 4'h1;
            end
          end
        end
        BS_HACK: begin
          if (scl_r) begin
            n.st = BS_IDLE;
          end
        end
        default: begin
          n.st = BS_IDLE;
          n.oe = 1'b0;
        end
      endcase
    end

    // Control register; writes to read-only codes fall through
    if (wr_go && s.cmd == `CMD_CTRL_WR) begin
      n.ctrl = wdat; // [R4] [R23]
    end
    if (sys_act) begin
      n.ctrl = ctrl_t'(`CTRL_RST); // [R4]
    end

    // Sticky status: set wins over a clear in the same cycle
    if (clr0) begin
      n.st0 = '0; // [R15]
    end
    n.st0 = n.st0 | rail_stat_t'(s.p2.f0); // [R13] [R14]
    if (clr1) begin
      n.st1.wd_reset_cause = 1'b0; // [R15]
      n.st1.fail = '0;
    end
    n.st1.wd_reset_cause = n.st1.wd_reset_cause | wd_st.expire; // [R17] [R22]
    n.st1.fail = n.st1.fail | s.p2.f1; // [R20] [R19]
    n.st1.wd_half_elapsed = wd_st.half; // [R18] [R19]
    n.st1.rsvd = 1'b0; // [R16]

    // Stretch the watchdog reset so the board sees a real pulse
    if (wd_st.expire) begin
      n.hold = HOLD_CYC;
    end else if (s.hold != '0) begin
      n.hold = s.hold - 10'h1;
    end
    n.sysrst = s.ctrl.full_reset_request // [R12]
             | (press & s.ctrl.handle_switch_action_sel) // [R7]
             | wd_st.expire | (s.hold != '0); // [R22]
    n.pwr = press & ~s.ctrl.handle_switch_action_sel; // [R7]

    // Blink phase runs freely so the LED starts mid-phase
    if (s.blink >= BLINK_CYC - 32'h1) begin
      n.blink = '0;
      n.blk = ~s.blk;
    end else begin
      n.blink = s.blink + 32'h1;
    end
    n.red = s.ctrl.red_led_blink & s.blk; // [R11]
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ==========================================
  // Outputs
  assign sda_o = 1'b0;
  assign sda_oe = s.oe;
  assign green_led = s.ctrl.green_led_on; // [R5]
  assign red_led = s.red;
  assign power_event = s.pwr;
  assign sys_reset_out = s.sysrst;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_addr_hit;
    s.st == BS_ADDR && scl_f && byte_done && !start && !stop &&
      s.sh[7:1] == `BUS_ADDR;
  endsequence
  sequence s_ctrl_wr;
    wr_go && s.cmd == `CMD_CTRL_WR && !sys_act;
  endsequence
  sequence s_read_hit;
    s_addr_hit ##0 s.sh[0];
  endsequence

  a_addr_ack: assert property (s_addr_hit |=> sda_oe ##1 sda_oe[*1]) // [R1]
    else $error("own address not acknowledged");
  a_addr_miss: assert property (s.st == BS_ADDR && scl_f && byte_done && !start && // [R1]
    !stop && s.sh[7:1] != `BUS_ADDR |=> !sda_oe && s.st == BS_IDLE)
    else $error("foreign address acknowledged");
  a_ctrl_write: assert property (s_ctrl_wr |=> s.ctrl == $past(wdat)) // [R4]
    else $error("control write not stored");
  a_ctrl_clear: assert property (sys_act |=> s.ctrl == ctrl_t'(`CTRL_RST)) // [R4]
    else $error("control not cleared by system reset");
  a_green_led: assert property (s_ctrl_wr |=> green_led == $past(wdat.green_led_on)) // [R5]
    else $error("green LED does not follow control");
  a_handle_off: assert property (s.ctrl.handle_switch_disable |=> !power_event) // [R6]
    else $error("disabled handle switch made a power event");
  a_handle_act: assert property (press |=> // [R7]
    ($past(s.ctrl.handle_switch_action_sel) ? sys_reset_out : power_event))
    else $error("handle switch action wrong");
  a_kick_restart: assert property (kick && !sys_act |=> wd_st.armed && !wd_st.half) // [R9]
    else $error("watchdog not restarted by retrigger");
  a_wd_idle: assert property (sys_act |=> !wd_st.armed) // [R10]
    else $error("watchdog armed during system reset");
  a_red_dark: assert property (!s.ctrl.red_led_blink |=> !red_led) // [R11]
    else $error("red LED lit while disabled");
  a_full_reset: assert property (s.ctrl.full_reset_request |=> sys_reset_out) // [R12]
    else $error("full reset not driven");
  a_rail_keep: assert property (!clr0 |=> s.st0 == ($past(s.st0) | $past(s.p2.f0))) // [R14]
    else $error("rail status lost or set wrongly");
  a_rail_clear: assert property (clr0 |=> s.st0 == $past(s.p2.f0)) // [R15]
    else $error("rail status clear wrong");
  a_rsvd_zero: assert property (s_read_hit ##0 (s.cmd == `CMD_ST1_RD) |=> !s.rsh[7]) // [R16]
    else $error("reserved status bit reads one");
  a_wd_cause: assert property (wd_st.expire |=> s.st1.wd_reset_cause && sys_reset_out) // [R22]
    else $error("watchdog expiry not recorded or not reset");
  a_half_live: assert property (!wd_st.armed |=> !s.st1.wd_half_elapsed) // [R18]
    else $error("half-time flag stuck");
  a_group_set: assert property (!clr1 |=> // [R20]
    s.st1.fail == ($past(s.st1.fail) | $past(s.p2.f1)))
    else $error("group status lost or set wrongly");
  a_rev_read: assert property (s_read_hit ##0 (s.cmd == `CMD_REV_RD) |=> // [R21]
    s.rsh == REV)
    else $error("revision byte wrong");
  a_ctrl_read: assert property (s_read_hit ##0 (s.cmd == `CMD_CTRL_RD) |=> // [R23]
    s.rsh == $past(s.ctrl))
    else $error("control readback wrong");
  a_stop_idle: assert property (stop |=> s.st == BS_IDLE && !sda_oe) // [R1]
    else $error("stop did not free the bus");
  a_read_bit: assert property (s.st == BS_ACK && s.aft == BS_RDATA && scl_f && // [R23]
    !start && !stop |=> sda_oe == !$past(s.rsh[7]))
    else $error("first read bit not driven");
  a_power_idle: assert property (!press |=> !power_event) // [R7]
    else $error("power event without a press");
  a_cause_keep: assert property (!clr1 && s.st1.wd_reset_cause |=> // [R19]
    s.st1.wd_reset_cause)
    else $error("watchdog cause lost");
  a_reset_hold: assert property (wd_st.expire |=> sys_reset_out[*8]) // [R22]
    else $error("watchdog reset pulse too short");
endmodule // smbus_board_control_status

// [hw/wd_timer.sv]
// Purpose: Watchdog interval counter with half-time flag
// Assumes: kick is a one-cycle pulse on every retrigger bit change
// Notes: Idle until the first kick; idle again after expiry
`include "board_ctl_params.svh"
module wd_timer
  import board_ctl_pkg::*;
#(
  parameter logic [31:0] C0 = 32'(`WD_T0_S * `CLK_HZ),
  parameter logic [31:0] C1 = 32'(`WD_T1_S * `CLK_HZ),
  parameter logic [31:0] C2 = 32'(`WD_T2_S * `CLK_HZ),
  parameter logic [31:0] C3 = 32'(`WD_T3_S * `CLK_HZ)
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic disarm,
  input wire logic kick,
  input wire logic [1:0] sel,
  output wd_stat_t stat
);
  wd_state_t s;
  wd_state_t n;
  logic [31:0] lim;

  // ==========================================
  // Interval select
  always_comb begin
    case (sel)
      2'h0: lim = C0;
      2'h1: lim = C1;
      2'h2: lim = C2;
      default: lim = C3;
    endcase
  end

  // ==========================================
  // Counter
  always_comb begin
    n = s;
    n.st.expire = 1'b0;
    if (disarm) begin // [R10]
      n.st.armed = 1'b0;
      n.cnt = '0;
    end else if (kick) begin // [R9] [R10]
      n.st.armed = 1'b1;
      n.cnt = '0;
    end else if (s.st.armed) begin
      // Compare with >= so a shortened interval still expires
      if (s.cnt >= lim - 32'h1) begin // [R8] [R22]
        n.st.armed = 1'b0;
        n.cnt = '0;
        n.st.expire = 1'b1;
      end else begin
        n.cnt = s.cnt + 32'h1;
      end
    end
    n.st.half = n.st.armed && (n.cnt >= (lim >> 1)); // [R18] [R19]
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign stat = s.st;

  a_wd_limit: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R8]
    s.st.armed && !disarm && !kick && s.cnt >= lim - 32'h1 |=> stat.expire && !stat.armed)
    else $error("watchdog did not expire at its interval");
  a_half_live: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R19]
    !stat.armed |-> !stat.half)
    else $error("half-time flag set while idle");
endmodule // wd_timer

// [tb/smbus_board_control_status_tb_top.sv]
// Purpose: Self-checking bench of the board control target
// Assumes: Short watchdog and blink counts set by parameter
// Notes: System reset loop-back is driven by hand, not from sys_reset_out
`include "board_ctl_params.svh"
module smbus_board_control_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] REV_TB = 8'h5A; // Arbitrary value
  localparam logic [31:0] WD_C [4] = '{32'h0BB8, 32'h0FA0, 32'h1388, 32'h1770};
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic handle_sw = 1'b0;
  logic sys_rst_in_b = 1'b1;
  logic [7:0] rail_fail = 8'h00;
  logic [4:0] group_fail = 5'h00;
  logic scl, sda, sda_o, sda_oe, green_led, red_led, power_event, sys_reset_out;
  int compares = 0;
  int n_errors = 0;
  logic kick = 1'b0;
  always #50 clk_sys = ~clk_sys;
  smbus_board_control_status #(.WD_CYC0(WD_C[0]), .WD_CYC1(WD_C[1]), .WD_CYC2(WD_C[2]),
    .WD_CYC3(WD_C[3]), .BLINK_CYC(32'h14), .REV(REV_TB)) DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .handle_sw(handle_sw), .sys_rst_in_b(sys_rst_in_b), .rail_fail(rail_fail),
    .group_fail(group_fail), .green_led(green_led), .red_led(red_led),
    .power_event(power_event), .sys_reset_out(sys_reset_out));
  smbus_host_model host (.clk_sys(clk_sys), .sda_dev_low(sda_oe && !sda_o), .scl(scl),
    .sda(sda));
  // ==========================================
  // Shared helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    logic a;
    host.write_reg(`BUS_ADDR, cmd, data, a);
    check("write ack", 8'h01, 8'(a));
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] d;
    logic a;
    host.read_reg(cmd, d, a);
    check("read ack", 8'h01, 8'(a));
    check($sformatf("read of %h", cmd), exp, d);
  endtask
  task automatic wait_rst(input logic lvl, input int bound);
    int n = 0;
    while (sys_reset_out !== lvl && n < bound) begin
      @(posedge clk_sys);
      n++;
    end
    check("reset out level", 8'(lvl), 8'(sys_reset_out));
    if (sys_reset_out !== lvl) give_verdict();
  endtask
  task automatic sys_reset_pulse();
    sys_rst_in_b <= 1'b0;
    cyc(4);
    sys_rst_in_b <= 1'b1;
    cyc(8);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_idle_regs();
    logic a;
    rd(`CMD_CTRL_RD, 8'h00);
    rd(`CMD_REV_RD, REV_TB);
    host.write_reg(7'h2E, `CMD_CTRL_WR, 8'h80, a);
    check("foreign ack", 8'h00, 8'(a));
    check("green after foreign", 8'h00, 8'(green_led));
    check("sda out level", 8'h00, 8'(sda_o));
    wr(`CMD_REV_RD, 8'h00);
    rd(`CMD_REV_RD, REV_TB);
    rd(8'h55, 8'h00);
    rd(`CMD_ST1_RD, 8'h00);
    cyc(6500);
    check("idle watchdog", 8'h00, 8'(sys_reset_out));
    $display("t_idle_regs done");
  endtask
  task automatic t_led_switch();
    logic prev;
    int n = 0;
    wr(`CMD_CTRL_WR, 8'h82);
    cyc(5);
    check("green led", 8'h01, 8'(green_led));
    rd(`CMD_CTRL_RD, 8'h82);
    prev = red_led;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      if (red_led !== prev) n++;
      prev = red_led;
    end
    check("red blinking", 8'h01, 8'(n >= 4));
    handle_sw <= 1'b1;
    cyc(8);
    check("power event", 8'h01, 8'(power_event));
    wr(`CMD_CTRL_WR, 8'h20);
    cyc(8);
    check("switch reset", 8'h02, {6'h00, sys_reset_out, power_event});
    wr(`CMD_CTRL_WR, 8'h60);
    cyc(8);
    check("switch ignored", 8'h00, {6'h00, sys_reset_out, power_event});
    handle_sw <= 1'b0;
    wr(`CMD_CTRL_WR, 8'h00);
    cyc(30);
    check("red dark", 8'h00, {6'h00, red_led, green_led});
    $display("t_led_switch done");
  endtask
  task automatic t_full_reset();
    wr(`CMD_CTRL_WR, 8'h81);
    cyc(5);
    check("full reset", 8'h01, 8'(sys_reset_out));
    sys_reset_pulse();
    check("reset released", 8'h00, {6'h00, sys_reset_out, green_led});
    rd(`CMD_CTRL_RD, 8'h00);
    $display("t_full_reset done");
  endtask
  task automatic t_status();
    rail_fail <= 8'hA5;
    group_fail <= 5'h13;
    cyc(2);
    rail_fail <= 8'h00;
    group_fail <= 5'h00;
    cyc(6);
    rd(`CMD_ST0_RD, 8'hA5);
    rd(`CMD_ST1_RD, 8'h13);
    sys_reset_pulse();
    rd(`CMD_ST0_RD, 8'hA5);
    rd(`CMD_ST1_RD, 8'h13);
    wr(`CMD_ST0_CLR, 8'hFF);
    rd(`CMD_ST0_RD, 8'h00);
    rd(`CMD_ST1_RD, 8'h13);
    wr(`CMD_ST1_CLR, 8'h00);
    rd(`CMD_ST1_RD, 8'h00);
    $display("t_status done");
  endtask
  task automatic t_watchdog();
    wr(`CMD_CTRL_WR, 8'h04);
    rd(`CMD_ST1_RD, 8'h00);
    cyc(1200);
    rd(`CMD_ST1_RD, 8'h20);
    wr(`CMD_CTRL_WR, 8'h00);
    rd(`CMD_ST1_RD, 8'h00);
    for (int i = 0; i < 4; i++) begin
      kick = ~kick;
      wr(`CMD_CTRL_WR, {3'b000, i[0], i[1], kick, 2'b00});
      cyc(int'(WD_C[i]) - 200);
      check("early expiry", 8'h00, 8'(sys_reset_out));
      wait_rst(1'b1, 400);
      wait_rst(1'b0, 1200);
      rd(`CMD_ST1_RD, 8'h40);
    end
    wr(`CMD_ST1_CLR, 8'h5A);
    rd(`CMD_ST1_RD, 8'h00);
    $display("t_watchdog done");
  endtask
  // ==========================================
  // Verdict and main sequence
  task automatic give_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    cyc(6);
    rst_b <= 1'b1;
    cyc(10);
    t_idle_regs();
    t_led_switch();
    t_full_reset();
    t_status();
    t_watchdog();
    give_verdict();
  end
endmodule // smbus_board_control_status_tb_top

// [tb/smbus_host_model.sv]
// Purpose: Bus host model that drives the management bus pins
// Assumes: Open-drain data line with pull-up; the host owns the clock
// Notes: Clock low 7 and high 6 system clocks, so data never moves near an edge
`include "board_ctl_params.svh"
module smbus_host_model (
  input wire logic clk_sys,
  input wire logic sda_dev_low,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic host_low = 1'b0;
  initial scl = 1'b1;
  // Released line floats to the pull-up level
  assign sda = ~(host_low | sda_dev_low);
  // ==========================================
  // Bit level
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic xfer_bit(input logic b, output logic r);
    wait_clk(4);
    host_low <= ~b;
    wait_clk(3);
    scl <= 1'b1;
    wait_clk(3);
    r = sda;
    wait_clk(3);
    scl <= 1'b0;
  endtask
  task automatic start();
    wait_clk(4);
    host_low <= 1'b0;
    wait_clk(3);
    scl <= 1'b1;
    wait_clk(6);
    host_low <= 1'b1;
    wait_clk(6);
    scl <= 1'b0;
  endtask
  task automatic stop();
    wait_clk(4);
    host_low <= 1'b1;
    wait_clk(3);
    scl <= 1'b1;
    wait_clk(6);
    host_low <= 1'b0;
    wait_clk(6);
  endtask
  // ==========================================
  // Byte and transfer level, one data byte per transfer
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(tx[i], r);
      rx[i] = r;
    end
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] cmd,
                           input logic [7:0] data, output logic acked);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    xfer_byte({addr, 1'b0}, rx, a0);
    xfer_byte(cmd, rx, a1);
    xfer_byte(data, rx, a2);
    stop();
    acked = a0 & a1 & a2;
  endtask
  task automatic read_reg(input logic [7:0] cmd, output logic [7:0] data, output logic acked);
    logic [7:0] rx;
    logic a0, a1, a2, na;
    start();
    xfer_byte({`BUS_ADDR, 1'b0}, rx, a0);
    xfer_byte(cmd, rx, a1);
    start();
    xfer_byte({`BUS_ADDR, 1'b1}, rx, a2);
    xfer_byte(8'hFF, data, na);
    stop();
    acked = a0 & a1 & a2;
  endtask
endmodule // smbus_host_model
